/* File: logic/spb_pkg.sv */
// constants, types and field layouts of the serial port bridge
//
// Summary of operation
// - printer status answered only when printer present
// - status codes 128 ok, 129 command, 130 frame; the bridge never returns 130
// - code 132 when printer busy beyond four seconds
// - each of four ports keeps own format
// - line command drives on, off or leaves lines
// - forced space transmit line returns to space
// - strip surplus high bits for short words
// - monitored readiness lines off give negative acknowledge
// - 8-bit concurrent mode relays lines uninterpreted
// - relay samples lines every 28.9 microseconds
// - slow short-word input deserialized, sent as byte
// - slow receiver oversamples 16 per bit
// - unused high bits of short characters set
// - framing error sticky, readable after concurrent mode
// - concurrent mode ends on stop, break, reset
// - readiness inputs tracked continuously, receive lines excluded
// - status query served by host during concurrency
// - low printer fault means absent, requests ignored
// - start space, lsb first, mark stop bits
package spb_pkg;
   localparam int          CLK_NS      = 10;
   localparam int          NPORT       = 4;
   localparam logic [7:0]  REG_FMT     = 8'h00;
   localparam logic [7:0]  REG_LINE    = 8'h04;
   localparam logic [7:0]  REG_BLOCK   = 8'h08;
   localparam logic [7:0]  REG_DATA    = 8'h0C;
   localparam logic [7:0]  REG_CONC    = 8'h10;
   localparam logic [7:0]  REG_STAT    = 8'h14;
   localparam logic [7:0]  REG_PRN     = 8'h18;
   localparam int          SAMPLE_NS   = 28900;
   localparam int          SAMPLE_CYC  = SAMPLE_NS / CLK_NS;
   localparam logic [11:0] SAMPLE_LAST = 12'(SAMPLE_CYC - 1);
   localparam int          PRN_TMO_MS  = 4000;
   localparam int          BUSYWAIT_US = 200;
   localparam int          STROBE_NS   = 1000;
   localparam logic [31:0] STROBE_LAST = 32'(STROBE_NS / CLK_NS - 1);
   localparam int          OVERSAMPLE  = 16;
   localparam logic [3:0]  OS_HALF     = 4'h7;
   localparam logic [3:0]  OS_LAST     = 4'hF;
   localparam int          SLOW_BAUD   = 300;
   localparam logic [15:0] SLOW_DIV    = 16'(1000000000 / (CLK_NS * SLOW_BAUD * OVERSAMPLE));
   localparam logic [7:0]  PRN_OK      = 8'h80;
   localparam logic [7:0]  PRN_BADCMD  = 8'h81;
   localparam logic [7:0]  PRN_FRAME   = 8'h82;
   localparam logic [7:0]  PRN_TIMEOUT = 8'h84;
   localparam logic [1:0]  ACT_OFF     = 2'h2;
   localparam logic [1:0]  ACT_ON      = 2'h3;
   localparam logic [1:0]  WS_8        = 2'h3;
   localparam logic [3:0]  BITS_MIN    = 4'h5;

   typedef struct packed {
      logic [15:0] div;
      logic [1:0]  wsize;
      logic        stop2;
      logic [2:0]  mon;
   } spb_cfg_t;
   localparam spb_cfg_t CFG_RESET = '{div: SLOW_DIV, wsize: WS_8, stop2: 1'b0, mon: 3'h0};

   typedef struct packed {
      logic [5:0]  rsv;
      logic [1:0]  port;
      spb_cfg_t    cfg;
   } spb_fmt_wr_t;
   typedef struct packed {
      logic [23:0] rsv;
      logic [1:0]  port_transmit_line;
      logic [1:0]  rts;
      logic [1:0]  dtr;
      logic [1:0]  port;
   } spb_line_wr_t;
   typedef struct packed {
      logic [27:0] rsv;
      logic        brk;
      logic        start;
      logic [1:0]  port;
   } spb_conc_wr_t;
   typedef struct packed {
      logic [21:0] rsv;
      logic [1:0]  kind;
      logic [7:0]  data;
   } spb_prn_wr_t;
   typedef struct packed {
      logic [21:0] rsv;
      logic        busy;
      logic        answered;
      logic [7:0]  code;
   } spb_prn_rd_t;

   typedef struct packed {
      logic [NPORT-1:0] rxd;
      logic [NPORT-1:0] dsr;
      logic [NPORT-1:0] cts;
      logic [NPORT-1:0] crx;
      logic             host_tx;
      logic             fault;
      logic             busy;
   } spb_pins_t;

   typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_START = 2'h1, TX_DATA = 2'h3, TX_STOP = 2'h2} spb_tx_t;
   typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h3, RX_STOP = 2'h2} spb_rx_t;
   typedef enum logic [1:0] {PR_IDLE = 2'h0, PR_STROBE = 2'h1, PR_WAITB = 2'h3, PR_BUSY = 2'h2} spb_pr_t;
endpackage

/* File: logic/spb_bridge.sv */
// serial port bridge: port formats, line control, block output, concurrent relay, printer
`timescale 1ns/10ps
`default_nettype none
module spb_bridge
   import spb_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC  = 400000000,
   parameter int unsigned BUSYWAIT_CYC = 20000
) (
   input  wire  logic             i_clock,
   input  wire  logic             i_rst_n,
   input  wire  logic [7:0]       i_addr,
   input  wire  logic [31:0]      i_wdata,
   input  wire  logic             i_wr,
   input  wire  logic             i_rd,
   output logic       [31:0]      o_rdata,
   input  wire  logic [NPORT-1:0] i_port_rxd,
   input  wire  logic [NPORT-1:0] i_port_dsr,
   input  wire  logic [NPORT-1:0] i_port_cts,
   input  wire  logic [NPORT-1:0] i_port_crx,
   output logic       [NPORT-1:0] o_port_txd,
   output logic       [NPORT-1:0] o_port_dtr,
   output logic       [NPORT-1:0] o_port_rts,
   input  wire  logic             i_host_tx,
   output logic                   o_host_rx,
   output logic       [7:0]       o_host_word,
   output logic                   o_host_word_valid,
   input  wire  logic             i_prn_fault,
   input  wire  logic             i_prn_busy,
   output logic       [7:0]       o_prn_data,
   output logic                   o_prn_strobe_n
);
   typedef struct packed {
      spb_cfg_t [NPORT-1:0]      cfg;
      logic [NPORT-1:0]          dtr;
      logic [NPORT-1:0]          rts;
      logic [NPORT-1:0]          xmt_idle;
      logic [NPORT-1:0]          txd;
      logic [NPORT-1:0][2:0]     hist;
      logic                      fe;
      logic [1:0]                blk_port;
      logic                      nak;
      spb_tx_t                   tx;
      logic [1:0]                tx_port;
      logic [7:0]                tx_sh;
      logic [2:0]                tx_bit;
      logic                      tx_stop;
      logic [19:0]               tx_cnt;
      logic                      conc;
      logic                      slow;
      logic [1:0]                cport;
      logic [11:0]               samp_cnt;
      logic                      pass_tx;
      logic                      host_rx;
      spb_rx_t                   rx;
      logic [15:0]               rx_cnt;
      logic [3:0]                rx_sub;
      logic [2:0]                rx_bit;
      logic [7:0]                rx_sh;
      logic [7:0]                word;
      logic                      word_valid;
      spb_pr_t                   prn;
      logic [31:0]               prn_cnt;
      logic [31:0]               tmo;
      logic [7:0]                prn_code;
      logic [7:0]                prn_data;
      logic                      strobe_n;
      logic                      answered;
      logic [31:0]               rdata;
   } spb_state_t;

   localparam spb_state_t ST_RESET = '{cfg: {NPORT{CFG_RESET}}, xmt_idle: '1, txd: '1,
                                      tx: TX_IDLE, rx: RX_IDLE, prn: PR_IDLE, host_rx: 1'b1,
                                      pass_tx: 1'b1, strobe_n: 1'b1, prn_code: PRN_OK,
                                      default: '0};

   spb_pins_t    sync1;
   spb_pins_t    pin;
   spb_state_t   st;
   spb_state_t   next_st;
   spb_cfg_t     c;
   spb_cfg_t     rc;
   spb_fmt_wr_t  fw;
   spb_line_wr_t lw;
   spb_conc_wr_t cw;
   spb_prn_wr_t  pw;
   spb_prn_rd_t  pr;
   logic [19:0]  bitc;
   logic         tick;
   logic         os_tick;
   logic         tx_line;
   logic         prn_done;

   function automatic logic [7:0] word_mask(input logic [1:0] ws);
      word_mask = 8'(8'hFF >> (WS_8 - ws));
   endfunction

   function automatic logic [3:0] word_bits(input logic [1:0] ws);
      word_bits = BITS_MIN + {2'h0, ws};
   endfunction

   // pins are asynchronous to i_clock; only the second stage is read
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1 <= '0;
         pin   <= '0;
      end else begin
         sync1 <= '{rxd: i_port_rxd, dsr: i_port_dsr, cts: i_port_cts, crx: i_port_crx,
                    host_tx: i_host_tx, fault: i_prn_fault, busy: i_prn_busy};
         pin   <= sync1;
      end
   end

   always_comb begin
      next_st    = st;
      fw         = spb_fmt_wr_t'(i_wdata[29:0]);
      lw         = spb_line_wr_t'(i_wdata);
      cw         = spb_conc_wr_t'(i_wdata);
      pw         = spb_prn_wr_t'(i_wdata);
      pr         = '{rsv: '0, busy: st.prn != PR_IDLE, answered: st.answered, code: st.prn_code};
      c          = st.cfg[st.tx_port];
      rc         = st.cfg[st.cport];
      bitc       = 20'(c.div) * 20'(OVERSAMPLE);
      tick       = (st.samp_cnt == SAMPLE_LAST);
      os_tick    = (st.rx_cnt == rc.div - 16'h1);
      tx_line    = 1'b1;
      prn_done   = 1'b0;
      next_st.rdata      = '0;
      next_st.word_valid = 1'b0;
      next_st.samp_cnt   = tick ? '0 : st.samp_cnt + 12'h1;

      if (i_wr && i_addr == REG_FMT) begin
         next_st.cfg[fw.port] = fw.cfg;
      end
      if (i_wr && i_addr == REG_LINE) begin
         if (lw.dtr[1]) next_st.dtr[lw.port] = (lw.dtr == ACT_ON);
         if (lw.rts[1]) next_st.rts[lw.port] = (lw.rts == ACT_ON);
         if (lw.port_transmit_line[1]) next_st.xmt_idle[lw.port] = (lw.port_transmit_line == ACT_ON);
      end
      if (i_wr && i_addr == REG_BLOCK) begin
         next_st.blk_port = lw.port;
         next_st.nak      = |(st.cfg[lw.port].mon & ~{pin.crx[lw.port], pin.cts[lw.port],
                                                      pin.dsr[lw.port]});
      end

      // start space, lsb first, mark stop
      case (st.tx)
         TX_IDLE: begin
            // bytes written while busy are dropped
            if (i_wr && i_addr == REG_DATA && !st.nak && !st.conc) begin
               next_st.tx_port = st.blk_port;
               next_st.tx_sh   = i_wdata[7:0] & word_mask(st.cfg[st.blk_port].wsize);
               next_st.tx_bit  = '0;
               next_st.tx_cnt  = '0;
               next_st.tx      = TX_START;
            end
         end
         default: begin
            tx_line = (st.tx == TX_START) ? 1'b0 : (st.tx == TX_DATA) ? st.tx_sh[0] : 1'b1;
            next_st.tx_cnt = st.tx_cnt + 20'h1;
            if (st.tx_cnt == bitc - 20'h1) begin
               next_st.tx_cnt = '0;
               case (st.tx)
                  TX_START: next_st.tx = TX_DATA;
                  TX_DATA: begin
                     next_st.tx_sh  = st.tx_sh >> 1;
                     next_st.tx_bit = st.tx_bit + 3'h1;
                     if (4'(st.tx_bit) == word_bits(c.wsize) - 4'h1) begin
                        next_st.tx      = TX_STOP;
                        next_st.tx_stop = c.stop2;
                     end
                  end
                  default: begin
                     next_st.tx_stop = 1'b0;
                     if (!st.tx_stop) next_st.tx = TX_IDLE;
                  end
               endcase
            end
         end
      endcase

      // start, stop and break of concurrent mode
      if (i_wr && i_addr == REG_CONC) begin
         if (cw.start && !cw.brk) begin
            next_st.conc  = 1'b1;
            next_st.cport = cw.port;
            // slow short-word input takes the receiver path
            next_st.slow  = st.cfg[cw.port].wsize != WS_8 && st.cfg[cw.port].div >= SLOW_DIV;
            next_st.rx    = RX_IDLE;
         end else begin
            next_st.conc  = 1'b0;
         end
      end
      next_st.host_rx = st.conc ? st.host_rx : 1'b1;
      if (st.conc && !st.slow && tick) begin
         next_st.host_rx = pin.rxd[st.cport];
         next_st.pass_tx = pin.host_tx;
      end
      // idle level follows the last forced state
      for (int p = 0; p < NPORT; p++) begin
         next_st.txd[p] = next_st.xmt_idle[p];
         if (st.tx != TX_IDLE && 2'(p) == st.tx_port) next_st.txd[p] = tx_line;
         if (st.conc && !st.slow && 2'(p) == st.cport) next_st.txd[p] = st.pass_tx;
      end

      if (st.conc && st.slow) begin
         next_st.rx_cnt = os_tick ? '0 : st.rx_cnt + 16'h1;
         if (os_tick) begin
            next_st.rx_sub = st.rx_sub + 4'h1;
            case (st.rx)
               RX_IDLE: begin
                  next_st.rx_sub = '0;
                  if (!pin.rxd[st.cport]) next_st.rx = RX_START;
               end
               RX_START: if (st.rx_sub == OS_HALF) begin
                  next_st.rx_sub = '0;
                  next_st.rx_bit = '0;
                  next_st.rx     = pin.rxd[st.cport] ? RX_IDLE : RX_DATA;
               end
               RX_DATA: if (st.rx_sub == OS_LAST) begin
                  next_st.rx_sh[st.rx_bit] = pin.rxd[st.cport];
                  next_st.rx_bit = st.rx_bit + 3'h1;
                  if (4'(st.rx_bit) == word_bits(rc.wsize) - 4'h1) next_st.rx = RX_STOP;
               end
               default: if (st.rx_sub == OS_LAST) begin
                  next_st.rx = RX_IDLE;
                  if (!pin.rxd[st.cport]) begin
                     next_st.fe = 1'b1;
                  end else begin
                     next_st.word       = (st.rx_sh & word_mask(rc.wsize)) | ~word_mask(rc.wsize);
                     next_st.word_valid = 1'b1;
                  end
               end
            endcase
         end
      end else begin
         next_st.rx_cnt = '0;
      end

      // status reads nothing and clears nothing while concurrent
      if (i_rd && i_addr == REG_STAT && !st.conc) begin
         next_st.rdata = 32'({st.fe, st.hist[st.blk_port]});
         next_st.hist[st.blk_port] = '0;
         next_st.fe = 1'b0;
      end
      // readiness tracking, set wins over clear
      for (int p = 0; p < NPORT; p++) begin
         next_st.hist[p] = next_st.hist[p] | ~{pin.crx[p], pin.cts[p], pin.dsr[p]};
      end
      if (i_rd && i_addr == REG_BLOCK) next_st.rdata = 32'({st.nak, st.tx != TX_IDLE});
      if (i_rd && i_addr == REG_CONC)  next_st.rdata = 32'({st.slow, st.conc});
      if (i_rd && i_addr == REG_PRN && pin.fault) next_st.rdata = 32'(pr);

      // requests ignored while fault is low
      if (st.prn == PR_IDLE && i_wr && i_addr == REG_PRN && pin.fault) begin
         next_st.answered = 1'b1;
         if (pw.kind != 2'h0) begin
            next_st.prn_code = PRN_BADCMD;
         end else begin
            next_st.prn_data = pw.data;
            next_st.strobe_n = 1'b0;
            next_st.prn_cnt  = '0;
            next_st.tmo      = '0;
            next_st.prn      = PR_STROBE;
         end
      end
      if (st.prn != PR_IDLE) begin
         next_st.prn_cnt = st.prn_cnt + 32'h1;
         next_st.tmo     = st.tmo + 32'h1;
         case (st.prn)
            PR_STROBE: if (st.prn_cnt == STROBE_LAST) begin
               next_st.strobe_n = 1'b1;
               next_st.prn_cnt  = '0;
               next_st.prn      = PR_WAITB;
            end
            PR_WAITB: begin
               if (pin.busy) next_st.prn = PR_BUSY;
               else if (st.prn_cnt == 32'(BUSYWAIT_CYC - 1)) prn_done = 1'b1;
            end
            default: prn_done = !pin.busy;
         endcase
         if (prn_done) begin
            next_st.prn      = PR_IDLE;
            next_st.prn_code = PRN_OK;
         end
         if (st.tmo == 32'(TIMEOUT_CYC - 1)) begin
            next_st.prn      = PR_IDLE;
            next_st.strobe_n = 1'b1;
            next_st.prn_code = PRN_TIMEOUT;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) st <= ST_RESET;
      else st <= next_st;
   end

   assign o_rdata           = st.rdata;
   assign o_port_txd        = st.txd;
   assign o_port_dtr        = st.dtr;
   assign o_port_rts        = st.rts;
   assign o_host_rx         = st.host_rx;
   assign o_host_word       = st.word;
   assign o_host_word_valid = st.word_valid;
   assign o_prn_data        = st.prn_data;
   assign o_prn_strobe_n    = st.strobe_n;
endmodule
`default_nettype wire

/* File: testbench/spb_bridge_props.sv */
// concurrent assertions on the bridge top ports
`timescale 1ns/10ps
`default_nettype none
module spb_bridge_props
   import spb_pkg::*;
(
   input wire logic             i_clock,
   input wire logic             i_rst_n,
   input wire logic [7:0]       i_addr,
   input wire logic [31:0]      i_wdata,
   input wire logic             i_wr,
   input wire logic             i_rd,
   input wire logic [31:0]      o_rdata,
   input wire logic [NPORT-1:0] o_port_txd,
   input wire logic [NPORT-1:0] o_port_dtr,
   input wire logic [NPORT-1:0] o_port_rts,
   input wire logic [7:0]       o_host_word,
   input wire logic             o_host_word_valid,
   input wire logic             i_prn_fault,
   input wire logic             o_prn_strobe_n
);
   default clocking dc @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   logic line_wr;
   assign line_wr = i_wr && i_addr == REG_LINE;

   dtr_on_a: assert property (
      line_wr && i_wdata[3:2] == ACT_ON |=> o_port_dtr[$past(i_wdata[1:0])])
      else $error("dtr not driven on");
   rts_off_a: assert property (
      line_wr && i_wdata[5:4] == ACT_OFF |=> !o_port_rts[$past(i_wdata[1:0])])
      else $error("rts not driven off");
   txd_space_a: assert property (
      line_wr && i_wdata[7:6] == ACT_OFF |-> ##2 !o_port_txd[$past(i_wdata[1:0], 2)])
      else $error("transmit line not forced to space");
   txd_mark_a: assert property (
      line_wr && i_wdata[7:6] == ACT_ON |-> ##2 o_port_txd[$past(i_wdata[1:0], 2)])
      else $error("transmit line not set to mark");
   idle_mark_a: assert property (
      $rose(i_rst_n) |-> &o_port_txd && o_prn_strobe_n)
      else $error("lines not idle after reset");
   prn_absent_a: assert property (
      i_wr && i_addr == REG_PRN && o_prn_strobe_n && !i_prn_fault && !$past(i_prn_fault)
      && !$past(i_prn_fault, 2) && !$past(i_prn_fault, 3) |=> o_prn_strobe_n[*3])
      else $error("printer strobed while absent");
   prn_silent_a: assert property (
      i_rd && i_addr == REG_PRN && !i_prn_fault && !$past(i_prn_fault)
      && !$past(i_prn_fault, 2) && !$past(i_prn_fault, 3) |=> o_rdata == 32'h0)
      else $error("printer status answered while absent");
   word_pad_a: assert property (
      o_host_word_valid |-> o_host_word[7])
      else $error("short word high bit not set");
endmodule
bind spb_bridge spb_bridge_props u_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_port_txd(o_port_txd), .o_port_dtr(o_port_dtr), .o_port_rts(o_port_rts),
   .o_host_word(o_host_word), .o_host_word_valid(o_host_word_valid),
   .i_prn_fault(i_prn_fault), .o_prn_strobe_n(o_prn_strobe_n));
`default_nettype wire

/* File: testbench/spb_far.sv */
// far-side model: readiness equipment and serial lines
`timescale 1ns/10ps
`default_nettype none
module spb_far (
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   input  wire logic [3:0] i_drop,
   output var  logic [3:0] o_ready,
   output var  logic       o_rxd,
   output var  logic       o_host_tx
);
   logic [13:0] cnt;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt     <= 14'h0;
         o_ready <= 4'hF;
      end else begin
         cnt <= cnt + 14'h1;
         if (cnt[9:0] == 10'h000) begin
            o_ready <= ~i_drop;
         end
      end
   end
   assign o_rxd     = ~cnt[12];
   assign o_host_tx = ~cnt[13];
endmodule
`default_nettype wire

/* File: testbench/test_spb_bridge.sv */
// self-checking bench for the serial port bridge
`timescale 1ns/10ps
`default_nettype none
module test_spb_bridge
   import spb_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        fault = 1'b1;
   logic        busy = 1'b0;
   logic [3:0]  drop = 4'h0;
   logic [31:0] rdata;
   logic [3:0]  txd, dtr, rts, ready;
   logic        hrx, rxl, htx, sn;
   int          n_fail = 0;
   int          checked = 0;
   int          seed = 12501;
   int          m_dtr[4], m_rts[4], m_txd[4];

   spb_far u_far (.i_clock(clk), .i_rst_n(rst_n), .i_drop(drop), .o_ready(ready),
      .o_rxd(rxl), .o_host_tx(htx));
   spb_bridge #(.TIMEOUT_CYC(2000), .BUSYWAIT_CYC(50)) dut (.i_clock(clk), .i_rst_n(rst_n),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_port_rxd({4{rxl}}), .i_port_dsr(ready), .i_port_cts(4'hF), .i_port_crx(4'hF),
      .o_port_txd(txd), .o_port_dtr(dtr), .o_port_rts(rts), .i_host_tx(htx),
      .o_host_rx(hrx), .o_host_word(), .o_host_word_valid(), .i_prn_fault(fault),
      .i_prn_busy(busy), .o_prn_data(), .o_prn_strobe_n(sn));

   always #5 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask
   function automatic logic [3:0] pk(input int m[4]);
      for (int i = 0; i < 4; i++) begin
         pk[i] = (m[i] != 0);
      end
   endfunction
   function automatic void act(inout int m, input logic [1:0] c);
      if (c == ACT_ON) begin
         m = 1;
      end else if (c == ACT_OFF) begin
         m = 0;
      end
   endfunction
   task automatic final_report;
      if (n_fail == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // run length is well under this span, so reaching it means a hang
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      final_report();
   end

   initial begin
      logic [31:0] r;
      logic [7:0]  d, c;
      spb_fmt_wr_t f;
      logic [7:0]  codes[3];
      logic [7:0]  q[$];
      int          p;
      codes = '{PRN_OK, PRN_BADCMD, PRN_TIMEOUT};
      m_dtr = '{default: 0};
      m_rts = '{default: 0};
      m_txd = '{default: 1};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1100);
      // history latches an off pulse, clears when read
      wr_reg(REG_BLOCK, 32'h0);
      rd_reg(REG_STAT, r);
      drop <= 4'h1;
      cyc(2100);
      drop <= 4'h0;
      cyc(2100);
      rd_reg(REG_STAT, r);
      chk("history set", r & 32'hF, 32'h1);
      rd_reg(REG_STAT, r);
      chk("history clear", r & 32'hF, 32'h0);
      for (int i = 0; i < 12; i++) begin
         r = $random(seed);
         p = r[1:0];
         wr_reg(REG_LINE, {24'h0, r[7:0]});
         act(m_dtr[p], r[3:2]);
         act(m_rts[p], r[5:4]);
         act(m_txd[p], r[7:6]);
         cyc(2);
         chk("dtr", 32'(dtr), 32'(pk(m_dtr)));
         chk("rts", 32'(rts), 32'(pk(m_rts)));
         chk("txd", 32'(txd), 32'(pk(m_txd)));
      end
      // port 1: forced space, 6-bit words, short bit time
      wr_reg(REG_LINE, 32'h81);
      f = '0;
      f.port = 2'h1;
      f.cfg.div = 16'h0002;
      f.cfg.wsize = 2'h1;
      wr_reg(REG_FMT, 32'(f));
      wr_reg(REG_BLOCK, 32'h1);
      rd_reg(REG_BLOCK, r);
      chk("block ok", r & 32'h3, 32'h0);
      d = 8'($random(seed));
      c = 8'h00;
      q.push_back(d);
      if (q.size() > 0) begin
         // no transfers while the block serializes
         wr_reg(REG_DATA, {24'h0, q.pop_front()});
      end
      cyc(18);
      chk("start bit", 32'(txd[1]), 32'h0);
      for (int i = 0; i < 6; i++) begin
         cyc(32);
         c[i] = txd[1];
      end
      chk("char", 32'(c), 32'(d & 8'h3F));
      cyc(32);
      chk("stop bit", 32'(txd[1]), 32'h1);
      cyc(32);
      chk("space after", 32'(txd[1]), 32'h0);
      wr_reg(REG_LINE, 32'hC1);
      // port 2 monitors its ready input, which is off
      f.port = 2'h2;
      f.cfg.mon = 3'h1;
      wr_reg(REG_FMT, 32'(f));
      drop <= 4'h4;
      cyc(1100);
      wr_reg(REG_BLOCK, 32'h2);
      rd_reg(REG_BLOCK, r);
      chk("nak", r & 32'h2, 32'h2);
      wr_reg(REG_DATA, 32'h0);
      cyc(20);
      chk("refused", 32'(txd[2]), 32'(m_txd[2]));
      drop <= 4'h0;
      wr_reg(REG_CONC, 32'h4);
      rd_reg(REG_CONC, r);
      chk("conc on", r & 32'h1, 32'h1);
      rd_reg(REG_STAT, r);
      chk("stat conc", r, 32'h0);
      repeat (3) begin
         c[0] = rxl;
         for (int k = 0; k < 5000 && rxl === c[0]; k++) @(posedge clk);
         cyc(3000);
         chk("relay rx", 32'(hrx), 32'(rxl));
         chk("relay tx", 32'(txd[0]), 32'(htx));
      end
      wr_reg(REG_CONC, 32'hC);
      rd_reg(REG_CONC, r);
      chk("break stop", r & 32'h1, 32'h0);
      wr_reg(REG_CONC, 32'h4);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(REG_CONC, r);
      chk("reset stop", r & 32'h1, 32'h0);
      for (int i = 0; i < 3; i++) begin
         busy <= (i == 2);
         wr_reg(REG_PRN, {22'h0, (i == 1) ? 2'h1 : 2'h0, 8'h41});
         cyc(i == 2 ? 2300 : 300);
         rd_reg(REG_PRN, r);
         chk("prn code", r & 32'h3FF, {22'h0, 2'b01, codes[i]});
      end
      busy  <= 1'b0;
      fault <= 1'b0;
      cyc(6);
      wr_reg(REG_PRN, 32'h41);
      rd_reg(REG_PRN, r);
      chk("prn silent", r, 32'h0);
      final_report();
   end
endmodule
`default_nettype wire
